// ===== logic/duart_front_pkg.sv
`default_nettype none
package duart_front_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int CHAN_N = 2;
  // bit positions inside the fractional divisor register
  localparam int FRAC_RS485_BIT = 6;
  localparam int FRAC_IR_BIT = 7;
  // reset pulse qualification
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 4;
  // direction output levels on the request-to-send pin
  localparam logic DIR_RECEIVE = 1'b1;
  localparam logic DIR_TRANSMIT = 1'b0;
  // levels forced during reset
  localparam logic SER_IDLE = 1'b1;
  localparam logic RTS_INACTIVE = 1'b1;
  localparam logic [DATA_W-1:0] DATA_IDLE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 3'h0;
endpackage : duart_front_pkg
`default_nettype wire

// ===== logic/duart_host_front.sv
// Functional notes
// - bus style input high selects dual chip selects; low selects single select plus address bit.
// - reset pin is active high in dual-select style, active low in single-select style.
// - reset pulse of at least 40 ns resets registers and outputs of both channels.
// - during reset transmit held high, receive ignored, other outputs in reset state.
// - half-duplex strap low starts both channels with automatic direction control.
// - software clears fractional divisor bit 6 to turn direction control off.
// - infrared strap low starts infrared mode; clearing divisor bit 7 leaves it.
// - direction goes to receive once the last stop bit has left the transmitter.
// - direction goes to transmit as soon as a byte loads into the transmitter.
// - without strap, direction control stays off until software writes bit 6 high.
// - direction output high means receive, low means transmit.
// - host port carries 8 data bits, 3 address lines, read and write strobes.
// - bus accesses are sampled on clock_i through the pin synchronisers, so the clock must run for them.
// - both channels share one host data bus; select logic picks the responder.
// - dual style: each select low picks its channel, both low picks both for a write and neither for a read.
// - single style: select low with address bit 0 picks A, 1 picks B.
// - address bit is ignored in the dual-select style.
`default_nettype none
module duart_host_front #(
  parameter int RST_CYC = duart_front_pkg::RESET_MIN_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic bus_style_i,
  input wire logic reset_pin_i,
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic channel_address_bit_i,
  input wire logic [duart_front_pkg::ADDR_W-1:0] addr_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [duart_front_pkg::DATA_W-1:0] data_i,
  output logic [duart_front_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [duart_front_pkg::DATA_W-1:0] chan_rdata_a_i,
  input wire logic [duart_front_pkg::DATA_W-1:0] chan_rdata_b_i,
  output logic [duart_front_pkg::CHAN_N-1:0] chan_rd_o,
  output logic [duart_front_pkg::CHAN_N-1:0] chan_wr_o,
  output logic [duart_front_pkg::ADDR_W-1:0] chan_addr_o,
  output logic [duart_front_pkg::DATA_W-1:0] chan_wdata_o,
  output logic chan_reset_o,
  input wire logic half_duplex_strap_n_i,
  input wire logic infrared_strap_n_i,
  input wire logic [duart_front_pkg::CHAN_N-1:0] frac_div_we_i,
  input wire logic [duart_front_pkg::DATA_W-1:0] frac_div_wdata_i,
  input wire logic [duart_front_pkg::CHAN_N-1:0] rts_n_i,
  input wire logic [duart_front_pkg::CHAN_N-1:0] tx_i,
  input wire logic [duart_front_pkg::CHAN_N-1:0] tx_load_i,
  input wire logic [duart_front_pkg::CHAN_N-1:0] tx_empty_i,
  input wire logic [duart_front_pkg::CHAN_N-1:0] rx_i,
  output logic [duart_front_pkg::CHAN_N-1:0] rx_o,
  output logic [duart_front_pkg::CHAN_N-1:0] tx_o,
  output logic [duart_front_pkg::CHAN_N-1:0] rts_n_o,
  output logic [duart_front_pkg::CHAN_N-1:0] rs485_mode_o,
  output logic [duart_front_pkg::CHAN_N-1:0] ir_mode_o
);

  localparam int DW = duart_front_pkg::DATA_W;
  localparam int AW = duart_front_pkg::ADDR_W;
  localparam int CN = duart_front_pkg::CHAN_N;
  localparam int CW = duart_front_pkg::RESET_CNT_W;
  localparam int PW = 9 + AW + DW + CN;

  // refused at elaboration: the counter must be able to reach RST_CYC
  if (RST_CYC < 1 || RST_CYC >= (1 << CW)) begin : g_bad_rst_cyc
    $error("RST_CYC out of range for the reset counter");
  end
  // the select decode and the write select latch pack exactly two channels
  if (CN != 2) begin : g_bad_chan_n
    $error("channel select decode serves exactly two channels");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every pin input crosses two flip-flops

  logic [PW-1:0] pins_meta_r;
  logic [PW-1:0] pins_r;
  logic [PW-1:0] pins_raw;

  assign pins_raw = {bus_style_i, reset_pin_i, chan_a_select_n_i, chan_b_select_n_i, channel_address_bit_i,
                     read_strobe_n_i, write_strobe_n_i, half_duplex_strap_n_i, infrared_strap_n_i,
                     addr_i, data_i, rx_i};

  always_ff @(posedge clock_i) begin
    pins_meta_r <= pins_raw;
    pins_r <= pins_meta_r;
  end

  logic style_s;
  logic rst_pin_s;
  logic csa_n_s;
  logic csb_n_s;
  logic abit_s;
  logic rd_n_s;
  logic wr_n_s;
  logic hd_strap_n_s;
  logic ir_strap_n_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] data_s;
  logic [CN-1:0] rx_s;

  assign {style_s, rst_pin_s, csa_n_s, csb_n_s, abit_s, rd_n_s, wr_n_s, hd_strap_n_s, ir_strap_n_s,
          addr_s, data_s, rx_s} = pins_r;

  ////////////////////////////////////////////////////////////////////////////
  // reset pin qualification

  logic pin_active;
  logic [CW-1:0] rst_cnt_r;
  logic dev_rst_r;
  logic in_rst;

  // limitation: the pin is sampled once a clock, so a pulse shorter than a
  // period may slip between two samples; the minimum pulse covers one period
  assign pin_active = style_s ? rst_pin_s : ~rst_pin_s;
  assign in_rst = rst_i | dev_rst_r;

  always_ff @(posedge clock_i) begin
    if (rst_i || !pin_active) begin
      rst_cnt_r <= '0;
    end else if (rst_cnt_r != CW'(RST_CYC)) begin
      rst_cnt_r <= rst_cnt_r + CW'(1);
    end
  end

  // a pulse must be seen for the full minimum before it takes effect, then holds while active
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dev_rst_r <= 1'b1;
    end else begin
      dev_rst_r <= pin_active && (rst_cnt_r >= CW'(RST_CYC - 1));
    end
  end

  always_ff @(posedge clock_i) begin
    chan_reset_o <= rst_i | dev_rst_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel select decode

  // decode runs on synchronised pins, so a select change costs two clocks
  // of latency but can never glitch a pulse into the wrong channel
  logic sel_a;
  logic sel_b;
  logic one_sel;

  always_comb begin
    if (style_s) begin
      sel_a = ~csa_n_s;
      sel_b = ~csb_n_s;
    end else begin
      sel_a = ~csa_n_s & ~abit_s;
      sel_b = ~csa_n_s & abit_s;
    end
  end

  // a read with both selected is illegal for the host; we simply stay off the bus
  assign one_sel = sel_a ^ sel_b;

  ////////////////////////////////////////////////////////////////////////////
  // host bus: reads

  logic rd_n_d_r;
  logic wr_n_d_r;
  logic rd_act;

  assign rd_act = ~rd_n_s & one_sel;

  always_ff @(posedge clock_i) begin
    if (in_rst) begin
      rd_n_d_r <= 1'b1;
      wr_n_d_r <= 1'b1;
    end else begin
      rd_n_d_r <= rd_n_s;
      wr_n_d_r <= wr_n_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (in_rst) begin
      data_oe_o <= 1'b0;
      data_o <= duart_front_pkg::DATA_IDLE;
    end else begin
      data_oe_o <= rd_act;
      if (rd_act) begin
        data_o <= sel_a ? chan_rdata_a_i : chan_rdata_b_i;
      end else begin
        data_o <= duart_front_pkg::DATA_IDLE;
      end
    end
  end

  // one read pulse per strobe so a popping register is read once
  always_ff @(posedge clock_i) begin
    if (in_rst) begin
      chan_rd_o <= '0;
    end else if (rd_n_d_r && !rd_n_s && one_sel) begin
      chan_rd_o <= {sel_b, sel_a};
    end else begin
      chan_rd_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host bus: writes commit on the trailing edge of the write strobe

  // committing on the trailing edge trades one clock of latency for data
  // that has settled for the whole strobe
  logic [CN-1:0] wr_sel_r;

  always_ff @(posedge clock_i) begin
    if (in_rst) begin
      chan_addr_o <= duart_front_pkg::ADDR_IDLE;
    end else if (!rd_n_s || !wr_n_s) begin
      chan_addr_o <= addr_s;
    end
  end

  // selects may rise with the strobe, so they are caught while it is still low
  always_ff @(posedge clock_i) begin
    if (in_rst) begin
      wr_sel_r <= '0;
      chan_wdata_o <= duart_front_pkg::DATA_IDLE;
    end else if (!wr_n_s) begin
      wr_sel_r <= {sel_b, sel_a};
      chan_wdata_o <= data_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (in_rst) begin
      chan_wr_o <= '0;
    end else if (!wr_n_d_r && wr_n_s) begin
      chan_wr_o <= wr_sel_r;
    end else begin
      chan_wr_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel mode, direction control and serial gating

  genvar ch;
  generate
    for (ch = 0; ch < CN; ch++) begin : g_chan
      logic rs485_r;
      logic ir_r;
      logic dir_r;

      // straps are sampled on every reset cycle, so the last one before release counts
      always_ff @(posedge clock_i) begin
        if (in_rst) begin
          rs485_r <= ~hd_strap_n_s;
        end else if (frac_div_we_i[ch]) begin
          rs485_r <= frac_div_wdata_i[duart_front_pkg::FRAC_RS485_BIT];
        end
      end

      always_ff @(posedge clock_i) begin
        if (in_rst) begin
          ir_r <= ~ir_strap_n_s;
        end else if (frac_div_we_i[ch]) begin
          ir_r <= frac_div_wdata_i[duart_front_pkg::FRAC_IR_BIT];
        end
      end

      // a load in the same cycle as empty wins: the new byte must go out
      always_ff @(posedge clock_i) begin
        if (in_rst) begin
          dir_r <= duart_front_pkg::DIR_RECEIVE;
        end else if (tx_load_i[ch]) begin
          dir_r <= duart_front_pkg::DIR_TRANSMIT;
        end else if (tx_empty_i[ch]) begin
          dir_r <= duart_front_pkg::DIR_RECEIVE;
        end
      end

      always_ff @(posedge clock_i) begin
        if (in_rst) begin
          rts_n_o[ch] <= duart_front_pkg::RTS_INACTIVE;
          tx_o[ch] <= duart_front_pkg::SER_IDLE;
          rx_o[ch] <= duart_front_pkg::SER_IDLE;
          rs485_mode_o[ch] <= 1'b0;
          ir_mode_o[ch] <= 1'b0;
        end else begin
          rts_n_o[ch] <= rs485_r ? dir_r : rts_n_i[ch];
          tx_o[ch] <= tx_i[ch];
          rx_o[ch] <= rx_s[ch];
          rs485_mode_o[ch] <= rs485_r;
          ir_mode_o[ch] <= ir_r;
        end
      end
    end
  endgenerate

endmodule : duart_host_front
`default_nettype wire

// ===== test/duart_host_front_sva.sv
`default_nettype none
module duart_host_front_sva (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic bus_style_i,
  input wire logic read_strobe_n_i,
  input wire logic [1:0] rts_n_i,
  input wire logic [1:0] tx_load_i,
  input wire logic [1:0] tx_empty_i,
  input wire logic [1:0] frac_div_we_i,
  input wire logic data_oe_o,
  input wire logic [1:0] chan_rd_o,
  input wire logic [1:0] chan_wr_o,
  input wire logic chan_reset_o,
  input wire logic [1:0] tx_o,
  input wire logic [1:0] rx_o,
  input wire logic [1:0] rts_n_o,
  input wire logic [1:0] rs485_mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////
  property p_oe_cause; data_oe_o |-> !$past(read_strobe_n_i, 3); endproperty
  property p_rd_pulse; chan_rd_o != 2'h0 |-> $onehot(chan_rd_o) ##1 chan_rd_o == 2'h0; endproperty
  property p_wr_pulse; chan_wr_o != 2'h0 |=> chan_wr_o == 2'h0; endproperty
  property p_wr_both; chan_wr_o == 2'h3 |-> $past(bus_style_i, 4); endproperty
  property p_rd_oe; $rose(chan_rd_o[0]) |-> data_oe_o; endproperty
  property p_reset_out; chan_reset_o |-> tx_o == 2'h3 && rx_o == 2'h3 && !data_oe_o; endproperty
  property p_dir_tx;
    !chan_reset_o && rs485_mode_o[1] && tx_load_i[1] && !frac_div_we_i[1]
      |-> ##2 rts_n_o[1] == duart_front_pkg::DIR_TRANSMIT;
  endproperty
  property p_dir_rx;
    !chan_reset_o && rs485_mode_o[1] && tx_empty_i[1] && !tx_load_i[1] && !frac_div_we_i[1]
      |-> ##2 rts_n_o[1] == duart_front_pkg::DIR_RECEIVE;
  endproperty
  // plain request-to-send path once the mode flag has been low for two edges
  property p_rts_pass;
    !rs485_mode_o[0] ##1 !rs485_mode_o[0] && !chan_reset_o |-> rts_n_o[0] == $past(rts_n_i[0]);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
  a_rd_pulse: assert property (p_rd_pulse) else $error("bad read pulse");
  a_wr_pulse: assert property (p_wr_pulse) else $error("long write pulse");
  a_wr_both: assert property (p_wr_both) else $error("dual write in single style");
  a_rd_oe: assert property (p_rd_oe) else $error("read pulse without drive");
  a_reset_out: assert property (p_reset_out) else $error("outputs live in reset");
  a_dir_tx: assert property (p_dir_tx) else $error("no transmit direction");
  a_dir_rx: assert property (p_dir_rx) else $error("no receive direction");
  a_rts_pass: assert property (p_rts_pass) else $error("rts not passed");
  c_wr_both: cover property (chan_wr_o == 2'h3);
  c_read: cover property ($rose(data_oe_o));
  c_dir: cover property (rs485_mode_o[1] && !rts_n_o[1]);
endmodule : duart_host_front_sva
bind duart_host_front duart_host_front_sva u_sva (.clock_i, .rst_i, .bus_style_i, .read_strobe_n_i,
  .rts_n_i, .tx_load_i, .tx_empty_i, .frac_div_we_i, .data_oe_o, .chan_rd_o, .chan_wr_o,
  .chan_reset_o, .tx_o, .rx_o, .rts_n_o, .rs485_mode_o);
`default_nettype wire

// ===== test/duart_host_front_tb.sv
`default_nettype none
module duart_host_front_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_style = 1'b1;
  logic strap_hd = 1'b0;
  logic strap_ir = 1'b0;
  logic pin, sel_a_n, sel_b_n, abit, rd_n, wr_n, oe, chan_reset;
  logic [2:0] addr, caddr, wr_addr;
  logic [7:0] wdata, data_o, cwdata, wr_data;
  logic [7:0] fdata = 8'h00;
  logic [1:0] fwe = 2'h0, rts_in = 2'h3, tx_load = 2'h0, tx_empty = 2'h3;
  logic [1:0] tx_in = 2'h1, rx_in = 2'h2;
  logic [1:0] rd_p, wr_p, tx_o, rx_o, rts_o, m485, mir, wr_seen, rd_seen, h;
  logic [8:0] q;
  int err_total = 0;
  int check_count = 0;
  duart_host_front uut (.clock_i(clock_i), .rst_i(rst_i), .bus_style_i(bus_style), .reset_pin_i(pin),
    .chan_a_select_n_i(sel_a_n), .chan_b_select_n_i(sel_b_n), .channel_address_bit_i(abit),
    .addr_i(addr), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .data_i(wdata), .data_o(data_o),
    .data_oe_o(oe), .chan_rdata_a_i(8'h3c), .chan_rdata_b_i(8'hc3), .chan_rd_o(rd_p), .chan_wr_o(wr_p),
    .chan_addr_o(caddr), .chan_wdata_o(cwdata), .chan_reset_o(chan_reset), .half_duplex_strap_n_i(strap_hd),
    .infrared_strap_n_i(strap_ir), .frac_div_we_i(fwe), .frac_div_wdata_i(fdata), .rts_n_i(rts_in),
    .tx_i(tx_in), .tx_load_i(tx_load), .tx_empty_i(tx_empty), .rx_i(rx_in), .rx_o(rx_o), .tx_o(tx_o),
    .rts_n_o(rts_o), .rs485_mode_o(m485), .ir_mode_o(mir));
  host_bus_model host (.clock_i(clock_i), .rdata_i(data_o), .rdata_oe_i(oe), .reset_pin_o(pin),
    .chan_a_select_n_o(sel_a_n), .chan_b_select_n_o(sel_b_n), .channel_address_bit_o(abit),
    .addr_o(addr), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .wdata_o(wdata));
  initial forever #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    rd_seen <= rd_seen | rd_p;
    if (wr_p !== 2'h0) begin
      wr_seen <= wr_p;
      {wr_addr, wr_data} <= {caddr, cwdata};
    end
  end
  ////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic wait_rst(input logic lvl);
    int k;
    k = 0;
    while (chan_reset !== lvl && k < 30) begin
      @(posedge clock_i);
      #1 k++;
    end
    if (k == 30) begin
      err_total++;
      test_done();
    end
  endtask : wait_rst
  task automatic bus(input logic rd, input logic [2:0] sel, input logic [1:0] hit);
    wr_seen = 2'h0;
    rd_seen = 2'h0;
    host.access(rd, sel, sel, 8'h50 + 8'(sel), q);
    #1;
    if (rd) begin
      chk(16'(q), {7'h0, hit != 2'h0, hit == 2'h1 ? 8'h3c : hit == 2'h2 ? 8'hc3 : 8'h00});
      chk(16'(rd_seen), 16'(hit));
    end else begin
      chk(16'(wr_seen), 16'(hit));
      if (hit != 2'h0) chk(16'({wr_addr, wr_data}), 16'({sel, 8'h50 + 8'(sel)}));
    end
  endtask : bus
  task automatic frac(input logic [1:0] ch, input logic [7:0] d);
    @(posedge clock_i);
    fwe <= ch;
    fdata <= d;
    @(posedge clock_i);
    fwe <= 2'h0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask : frac
  ////////////////////////
  initial begin
    repeat (19) @(posedge clock_i);
    #1 chk(16'({chan_reset, tx_o, rx_o, oe, rts_o, m485}), 16'h3ec);
    @(posedge clock_i);
    rst_i <= 1'b0;
    wait_rst(1'b0);
    repeat (3) @(posedge clock_i);
    #1 chk(16'({m485, mir, tx_o, rx_o}), 16'({4'hf, tx_in, rx_in}));
    @(posedge clock_i);
    tx_load <= 2'h2;
    tx_empty <= 2'h0;
    @(posedge clock_i);
    tx_load <= 2'h0;
    repeat (2) @(posedge clock_i);
    #1 chk(16'(rts_o[1]), 16'h0);
    @(posedge clock_i);
    tx_empty <= 2'h3;
    rts_in <= 2'h2;
    repeat (3) @(posedge clock_i);
    #1 chk(16'(rts_o[1]), 16'h1);
    frac(2'h1, 8'h00);
    chk(16'({m485, mir, rts_o[0]}), 16'h14);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, {1'b1, 2'(i)}, ~2'(i));
      if (i != 0) bus(1'b1, {1'b1, 2'(i)}, ~2'(i));
    end
    @(posedge clock_i);
    bus_style <= 1'b0;
    {strap_hd, strap_ir} <= 2'h3;
    {tx_in, rx_in} <= 4'h9;
    #1 wait_rst(1'b1);
    host.drive_pin(1'b1);
    wait_rst(1'b0);
    frac(2'h2, 8'h40);
    chk(16'({m485, mir}), 16'h8);
    for (int j = 0; j < 4; j++) begin
      h = j[1] ? 2'h0 : (j[0] ? 2'h2 : 2'h1);
      bus(1'b0, {j[0], 1'b0, j[1]}, h);
      bus(1'b1, {j[0], 1'b0, j[1]}, h);
    end
    @(posedge clock_i);
    bus_style <= 1'b1;
    #1 wait_rst(1'b1);
    host.drive_pin(1'b0);
    wait_rst(1'b0);
    repeat (3) @(posedge clock_i);
    #1 chk(16'({m485, mir, tx_o, rx_o}), 16'({4'h0, tx_in, rx_in}));
    test_done();
  end
endmodule : duart_host_front_tb
`default_nettype wire

// ===== test/host_bus_model.sv
`default_nettype none
module host_bus_model (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_oe_i,
  output logic reset_pin_o,
  output logic chan_a_select_n_o,
  output logic chan_b_select_n_o,
  output logic channel_address_bit_o,
  output logic [2:0] addr_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {reset_pin_o, channel_address_bit_o, addr_o, wdata_o} = 13'h0;
    {chan_a_select_n_o, chan_b_select_n_o, read_strobe_n_o, write_strobe_n_o} = 4'hf;
  end
  ////////////////////////
  // sel is {address bit, b select, a select}; q is {drive, data} seen mid-read
  task automatic access(input logic rd, input logic [2:0] sel, input logic [2:0] a,
    input logic [7:0] d, output logic [8:0] q);
    @(posedge clock_i);
    {channel_address_bit_o, chan_b_select_n_o, chan_a_select_n_o} <= sel;
    addr_o <= a;
    wdata_o <= d;
    repeat (3) @(posedge clock_i);
    if (rd) read_strobe_n_o <= 1'b0;
    else write_strobe_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1 q = {rdata_oe_i, rdata_i};
    @(posedge clock_i);
    read_strobe_n_o <= 1'b1;
    write_strobe_n_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    {chan_b_select_n_o, chan_a_select_n_o} <= 2'h3;
    // released lines flip so a stale value cannot pass for a hold
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : access
  task automatic drive_pin(input logic lvl);
    @(posedge clock_i);
    reset_pin_o <= lvl;
  endtask : drive_pin
endmodule : host_bus_model
`default_nettype wire
